// file: rtl/pirq_pkg.sv
// constants and register map of the peripheral interrupt flag and enable block
package pirq_pkg;
  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [5:0] OFS_ENABLE4  = 6'h00;
  localparam logic [5:0] OFS_FLAGS1   = 6'h04;
  localparam logic [5:0] OFS_FLAGS2   = 6'h08;
  localparam logic [5:0] OFS_FLAGS3   = 6'h0C;
  localparam logic [5:0] OFS_FLAGS4   = 6'h10;
  localparam logic [5:0] OFS_MAIN_CTL = 6'h14;
  localparam logic [5:0] OFS_IRQ_STAT = 6'h18;
  localparam logic [5:0] OFS_IRQ_EN   = 6'h1C;
  localparam logic [5:0] OFS_IRQ_CLR  = 6'h20;
  // ----------------------------------------------------------------
  // field layout, index 0 is group 1
  // ----------------------------------------------------------------
  localparam logic [3:0][7:0] FLAG_IMPL  = {8'h33, 8'h7A, 8'hFD, 8'hFF};
  localparam logic [3:0][7:0] FLAG_SWMSK = {8'h33, 8'h7A, 8'hFD, 8'hCF};
  localparam logic [7:0]      ENABLE4_IMPL = 8'h33;
  localparam int              SERIAL1_RX_BIT = 5;
  localparam int              SERIAL1_TX_BIT = 4;
  localparam int              GLOBAL_EN_BIT  = 7;
  localparam int              GATE_EN_BIT    = 6;
  localparam logic [7:0]      MAIN_CTL_IMPL  = 8'hC0;
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  FLAG_RESET    = 8'h00;
  localparam logic [7:0]  ENABLE_RESET  = 8'h00;
  localparam logic [7:0]  CTL_RESET     = 8'h00;
  localparam logic [3:0]  STAT_RESET    = 4'h0;
  localparam logic [31:0] RDATA_RESET   = 32'h0000_0000;
endpackage

// file: rtl/flag_if.sv
// flag register group connection between top and flag storage
`timescale 1ns/100ps
interface flag_if;
  logic       wr;
  logic [7:0] wdata;
  logic [7:0] evt;
  logic [7:0] q;
  modport ctl (output wr, output wdata, output evt, input q);
  modport store (input wr, input wdata, input evt, output q);
endinterface

// file: rtl/flag_reg.sv
// one group of eight peripheral request flags
`timescale 1ns/100ps
module flag_reg
  import pirq_pkg::*;
#(
  parameter logic [7:0] IMPL  = 8'hFF,
  parameter logic [7:0] SWMSK = 8'hFF
) (
  input wire logic mclk,
  input wire logic rstn,
  flag_if.store    fi
);
  logic [7:0] flag_q;
  logic [7:0] flag_d;

  // ----------------------------------------------------------------
  // next value
  // ----------------------------------------------------------------
  always_comb begin
    // hw-only bits follow their source; set wins over a software zero
    flag_d = IMPL & ((SWMSK & ((fi.wr ? fi.wdata : flag_q) | fi.evt))
                     | (~SWMSK & fi.evt));
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      flag_q <= FLAG_RESET;
    end else begin
      flag_q <= flag_d;
    end
  end

  assign fi.q = flag_q;

  chk_unimpl_zero: assert property (@(posedge mclk) disable iff (!rstn)
    (flag_q & ~IMPL) == 8'h00)
    else $error("unimplemented flag bit set");

  chk_set_wins: assert property (@(posedge mclk) disable iff (!rstn)
    (fi.wr && (fi.evt & IMPL & SWMSK) != 8'h00)
      |=> ((flag_q & $past(fi.evt & IMPL & SWMSK)) == $past(fi.evt & IMPL & SWMSK)))
    else $error("event lost against software clear");

  chk_flag_holds: assert property (@(posedge mclk) disable iff (!rstn)
    (!fi.wr && fi.evt == 8'h00) |=> ((flag_q & SWMSK) == ($past(flag_q) & SWMSK)))
    else $error("writable flag changed without cause");
endmodule

// file: rtl/periph_irq.sv
// peripheral interrupt flags, group 4 enables, gating and avalon slave
`timescale 1ns/100ps
module periph_irq
  import pirq_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic [5:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [3:0]  byteenable,
  input  wire logic [31:0] writedata,
  output      logic [31:0] readdata,
  output      logic        waitrequest,
  input  wire logic [7:0]  flags1_set,
  input  wire logic [7:0]  flags2_set,
  input  wire logic [7:0]  flags3_set,
  input  wire logic [7:0]  flags4_set,
  input  wire logic [7:0]  enable_group1,
  input  wire logic [7:0]  enable_group2,
  input  wire logic [7:0]  enable_group3,
  output      logic        periph_irq_req,
  output      logic        irq
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0]       enable4_q;
  logic [7:0]       enable4_d;
  logic [7:0]       main_ctl_q;
  logic [7:0]       main_ctl_d;
  logic [3:0]       stat_q;
  logic [3:0]       stat_d;
  logic [3:0]       stat_en_q;
  logic [3:0]       stat_en_d;
  logic [3:0][7:0]  prev_q;
  logic [31:0]      rdata_q;
  logic [31:0]      rdata_d;
  logic             rd_done_q;
  logic             rd_done_d;
  logic [3:0][7:0]  flags_q;
  logic [3:0][7:0]  flags_evt;
  logic [3:0][7:0]  enables;
  logic [3:0]       grp_rise;
  logic             wr_lane0;
  logic [7:0]       pending;

  assign wr_lane0 = write & byteenable[0];
  assign flags_evt = {flags4_set, flags3_set, flags2_set, flags1_set};
  // outer enables of groups 1-3 live elsewhere
  assign enables = {enable4_q, enable_group3, enable_group2, enable_group1};

  // ----------------------------------------------------------------
  // flag groups
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : grp
      flag_if fif ();
      assign fif.wr    = wr_lane0 && (address == OFS_FLAGS1 + 6'(4 * g));
      assign fif.wdata = writedata[7:0];
      assign fif.evt   = flags_evt[g];
      assign flags_q[g] = fif.q;
      assign grp_rise[g] = |(flags_q[g] & ~prev_q[g]);
      // one flag at one counts as pending when enabled
      assign pending[g] = |(flags_q[g] & enables[g]);
      assign pending[g + 4] = 1'b0;
      flag_reg #(
        .IMPL  (FLAG_IMPL[g]),
        .SWMSK (FLAG_SWMSK[g])
      ) u_flags (
        .mclk (mclk),
        .rstn (rstn),
        .fi   (fif.store)
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // core request
  // ----------------------------------------------------------------
  assign periph_irq_req = main_ctl_q[GLOBAL_EN_BIT]
                        & main_ctl_q[GATE_EN_BIT]
                        & (|pending[3:0]);

  // ----------------------------------------------------------------
  // registers, next values
  // ----------------------------------------------------------------
  always_comb begin
    enable4_d  = enable4_q;
    main_ctl_d = main_ctl_q;
    stat_en_d  = stat_en_q;
    stat_d     = stat_q | grp_rise;
    if (wr_lane0) begin
      unique case (address)
        OFS_ENABLE4:  enable4_d  = writedata[7:0] & ENABLE4_IMPL;
        OFS_MAIN_CTL: main_ctl_d = writedata[7:0] & MAIN_CTL_IMPL;
        OFS_IRQ_EN:   stat_en_d  = writedata[3:0];
        // set wins over the clear in the same cycle
        OFS_IRQ_CLR:  stat_d     = (stat_q & ~writedata[3:0]) | grp_rise;
        default:      ;
      endcase
    end
  end

  always_comb begin
    rd_done_d = read & ~rd_done_q;
    rdata_d   = rdata_q;
    if (read && !rd_done_q) begin
      unique case (address)
        OFS_ENABLE4:  rdata_d = {24'h00_0000, enable4_q};
        OFS_FLAGS1:   rdata_d = {24'h00_0000, flags_q[0]};
        OFS_FLAGS2:   rdata_d = {24'h00_0000, flags_q[1]};
        OFS_FLAGS3:   rdata_d = {24'h00_0000, flags_q[2]};
        OFS_FLAGS4:   rdata_d = {24'h00_0000, flags_q[3]};
        OFS_MAIN_CTL: rdata_d = {24'h00_0000, main_ctl_q};
        OFS_IRQ_STAT: rdata_d = {28'h000_0000, stat_q};
        OFS_IRQ_EN:   rdata_d = {28'h000_0000, stat_en_q};
        // clear register is write-only; unmapped reads zero
        default:      rdata_d = RDATA_RESET;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      enable4_q  <= ENABLE_RESET;
      main_ctl_q <= CTL_RESET;
      stat_q     <= STAT_RESET;
      stat_en_q  <= STAT_RESET;
      prev_q     <= {4{FLAG_RESET}};
      rdata_q    <= RDATA_RESET;
      rd_done_q  <= 1'b0;
    end else begin
      enable4_q  <= enable4_d;
      main_ctl_q <= main_ctl_d;
      stat_q     <= stat_d;
      stat_en_q  <= stat_en_d;
      prev_q     <= flags_q;
      rdata_q    <= rdata_d;
      rd_done_q  <= rd_done_d;
    end
  end

  // reads take two cycles so read data comes straight from a flop
  assign waitrequest = read & ~rd_done_q;
  assign readdata    = rdata_q;
  assign irq         = |(stat_q & stat_en_q);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_gate_blocks: assert property (@(posedge mclk) disable iff (!rstn)
    !main_ctl_q[GATE_EN_BIT] |-> !periph_irq_req)
    else $error("request passed a closed peripheral gate");

  chk_global_blocks: assert property (@(posedge mclk) disable iff (!rstn)
    !main_ctl_q[GLOBAL_EN_BIT] |-> !periph_irq_req)
    else $error("request passed with global enable clear");

  chk_req_pending: assert property (@(posedge mclk) disable iff (!rstn)
    (main_ctl_q[GLOBAL_EN_BIT] && main_ctl_q[GATE_EN_BIT]
      && (flags_q[3] & enable4_q) != 8'h00) |-> periph_irq_req)
    else $error("enabled pending flag did not raise request");

  chk_enable_mask: assert property (@(posedge mclk) disable iff (!rstn)
    (enable4_q == 8'h00 && enable_group1 == 8'h00 && enable_group2 == 8'h00
      && enable_group3 == 8'h00) |-> !periph_irq_req)
    else $error("request raised with all enables clear");

  chk_event_sets: assert property (@(posedge mclk) disable iff (!rstn)
    flags2_set[7] |=> flags_q[1][7] ##1 (flags_q[1][7] || $past(wr_lane0)))
    else $error("oscillator fail event did not set its flag");

  chk_serial_level: assert property (@(posedge mclk) disable iff (!rstn)
    ##1 (flags_q[0][SERIAL1_RX_BIT] == $past(flags1_set[SERIAL1_RX_BIT]))
      && (flags_q[0][SERIAL1_TX_BIT] == $past(flags1_set[SERIAL1_TX_BIT])))
    else $error("serial1 flag not following serial unit");

  chk_enable_unimpl: assert property (@(posedge mclk) disable iff (!rstn)
    (enable4_q & ~ENABLE4_IMPL) == 8'h00)
    else $error("unimplemented enable bit set");

  chk_reset_zero: assert property (@(posedge mclk)
    $rose(rstn) |-> (enable4_q == 8'h00 && main_ctl_q == 8'h00 && flags_q == 32'h0000_0000))
    else $error("state not zero after reset");

  chk_read_answer: assert property (@(posedge mclk) disable iff (!rstn)
    (read && waitrequest && address == OFS_FLAGS3)
      |=> (!waitrequest && readdata[7] == 1'b0 && readdata[2] == 1'b0 && readdata[0] == 1'b0))
    else $error("read not answered or unimplemented bit nonzero");
endmodule

// file: bench/event_src.sv
// event source model standing for the on-chip peripherals
`timescale 1ns/100ps
module event_src (
  input  wire logic       fire,
  input  wire logic [1:0] grp,
  input  wire logic [7:0] mask,
  input  wire logic [1:0] serial1_lvl,
  output      logic [7:0] flags1_set,
  output      logic [7:0] flags2_set,
  output      logic [7:0] flags3_set,
  output      logic [7:0] flags4_set
);
  logic [7:0] p;
  // ----------------------------------------------------------------
  // one-cycle pulses except the serial1 levels, blind to any enable
  // ----------------------------------------------------------------
  assign p = fire ? mask : 8'h00;
  // serial1 bits are levels owned by the serial unit
  assign flags1_set = {(grp == 2'd0) ? p[7:6] : 2'b00, serial1_lvl,
                       (grp == 2'd0) ? p[3:0] : 4'h0};
  assign flags2_set = (grp == 2'd1) ? p : 8'h00;
  assign flags3_set = (grp == 2'd2) ? p : 8'h00;
  assign flags4_set = (grp == 2'd3) ? p : 8'h00;
endmodule

// file: bench/tb_top.sv
// self-checking bench for the peripheral interrupt block
`timescale 1ns/100ps
module tb_top;
  import pirq_pkg::*;
  logic            mclk = 1'b0;
  logic            rstn = 1'b0;
  logic [5:0]      address = 6'h00;
  logic            read = 1'b0;
  logic            write = 1'b0;
  logic [3:0]      byteenable = 4'h0;
  logic [31:0]     writedata = 32'h0000_0000;
  logic [31:0]     readdata;
  logic            waitrequest;
  logic            periph_irq_req;
  logic            irq;
  logic [3:0][7:0] set_w;
  logic [2:0][7:0] en_g = '0;
  logic            fire = 1'b0;
  logic [1:0]      grp = 2'd0;
  logic [7:0]      mask = 8'h00;
  logic [1:0]      s1_lvl = 2'b00;
  logic [7:0]      fl[4];
  logic [7:0]      en4, ctl;
  logic [3:0]      stat, ien;
  logic [31:0]     q;
  int              err_total, n_compared, seed, g;
  always #20 mclk = ~mclk;
  event_src i_event_src (.fire(fire), .grp(grp), .mask(mask), .serial1_lvl(s1_lvl),
    .flags1_set(set_w[0]), .flags2_set(set_w[1]), .flags3_set(set_w[2]), .flags4_set(set_w[3]));
  periph_irq i_periph_irq (.mclk(mclk), .rstn(rstn), .address(address), .read(read),
    .write(write), .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .flags1_set(set_w[0]), .flags2_set(set_w[1]),
    .flags3_set(set_w[2]), .flags4_set(set_w[3]), .enable_group1(en_g[0]),
    .enable_group2(en_g[1]), .enable_group3(en_g[2]), .periph_irq_req(periph_irq_req),
    .irq(irq));
  // ----------------------------------------------------------------
  // model and helpers
  // ----------------------------------------------------------------
  task automatic summarize();
    if (err_total == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic upd(input int k, input logic [7:0] v);
    if ((v & ~fl[k]) != 8'h00) stat[k] = 1'b1;
    fl[k] = v;
  endtask
  function automatic logic ex_req();
    logic a;
    a = |(fl[3] & en4);
    for (int k = 0; k < 3; k++) a |= |(fl[k] & en_g[k]);
    return ctl[7] & ctl[6] & a;
  endfunction
  // waits are bounded; the master releases only after waitrequest low
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    address <= a;
    writedata <= d;
    byteenable <= 4'h1;
    if (wr) write <= 1'b1;
    else read <= 1'b1;
    // waitrequest and read data are sampled at the rising edge itself
    do begin
      @(posedge mclk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    if (n >= 50) err_total++;
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic wreg(input logic [5:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
    if (a >= OFS_FLAGS1 && a <= OFS_FLAGS4) begin
      g = (a - OFS_FLAGS1) / 4;
      upd(g, (fl[g] & ~FLAG_SWMSK[g]) | (d[7:0] & FLAG_SWMSK[g]));
    end
    if (a == OFS_ENABLE4) en4 = d[7:0] & 8'h33;
    if (a == OFS_MAIN_CTL) ctl = d[7:0] & 8'hC0;
    if (a == OFS_IRQ_EN) ien = d[3:0];
    if (a == OFS_IRQ_CLR) stat &= ~d[3:0];
  endtask
  task automatic rchk(input logic [5:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    check(q, e);
  endtask
  task automatic ev(input int k, input logic [7:0] m, input logic [1:0] lv, input logic clr);
    @(posedge mclk);
    fire <= 1'b1;
    grp <= 2'(k);
    mask <= m;
    // serial1 levels move only with group 1 events, as the model assumes
    if (k == 0) s1_lvl <= lv;
    if (clr) begin
      write <= 1'b1;
      address <= OFS_FLAGS1 + 6'(4 * k);
      writedata <= 32'h0000_0000;
      byteenable <= 4'h1;
    end
    @(posedge mclk);
    fire <= 1'b0;
    write <= 1'b0;
    if (clr) upd(k, (fl[k] & ~FLAG_SWMSK[k]) | (m & FLAG_SWMSK[k]));
    else if (k == 0) upd(0, ((fl[0] | m) & 8'hCF) | {2'b00, lv, 4'h0});
    else upd(k, fl[k] | (m & FLAG_IMPL[k]));
  endtask
  task automatic chk_all();
    // status lags a flag rise by one edge
    @(posedge mclk);
    @(negedge mclk);
    check(32'(periph_irq_req), 32'(ex_req()));
    check(32'(irq), 32'(|(stat & ien)));
    for (int k = 0; k < 4; k++) rchk(OFS_FLAGS1 + 6'(4 * k), 32'(fl[k]));
    rchk(OFS_ENABLE4, 32'(en4));
    rchk(OFS_IRQ_STAT, 32'(stat));
  endtask
  task automatic zero();
    for (int k = 0; k < 4; k++) fl[k] = 8'h00;
    {en4, ctl, stat, ien} = '0;
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge mclk);
    err_total++;
    summarize();
  end
  initial begin
    seed = 32'h6925_ff22;
    zero();
    repeat (20) @(posedge mclk);
    rstn <= 1'b1;
    chk_all();
    rchk(6'h24, 32'h0000_0000);
    for (int k = 0; k < 4; k++) wreg(OFS_FLAGS1 + 6'(4 * k), 32'h0000_00FF);
    wreg(OFS_ENABLE4, 32'h0000_00FF);
    wreg(OFS_IRQ_EN, 32'h0000_000F);
    chk_all();
    rchk(OFS_IRQ_CLR, 32'h0000_0000);
    for (int i = 0; i < 40; i++) begin
      @(posedge mclk);
      en_g <= 24'($random(seed));
      wreg(OFS_MAIN_CTL, 32'($random(seed)));
      wreg(OFS_ENABLE4, 32'($random(seed)));
      wreg(OFS_IRQ_EN, 32'($random(seed)));
      ev($unsigned($random(seed)) % 4, 8'($random(seed)), 2'($random(seed)), 1'b0);
      chk_all();
      // clear stale flags before the next enables
      if (i % 4 == 3) for (int k = 0; k < 4; k++) wreg(OFS_FLAGS1 + 6'(4 * k), 0);
      if (i % 4 == 3) wreg(OFS_IRQ_CLR, 32'($random(seed)));
    end
    ev(3, 8'h02, 2'b00, 1'b1);
    ev(3, 8'h01, 2'b00, 1'b1);
    chk_all();
    for (int k = 0; k < 4; k++) begin
      wreg(OFS_MAIN_CTL, 32'(k << 6));
      chk_all();
    end
    @(posedge mclk);
    rstn <= 1'b0;
    s1_lvl <= 2'b00;
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    zero();
    chk_all();
    summarize();
  end
endmodule
